// ==== hw/sbsd_consts.svh ====
// Constants for the synchronous burst SRAM command decoder
`ifndef SBSD_CONSTS_SVH
`define SBSD_CONSTS_SVH
`define SBSD_ADDR_W 16
`define SBSD_DATA_W 32
`define SBSD_LANES 4
`define SBSD_LANE_W 8
`define SBSD_DEPTH 65536
`define SBSD_CNT_RST 2'h0
`define SBSD_CNT_STEP 2'h1
`endif

// ==== hw/sbsd_pkg.sv ====
// Types for the burst SRAM command decoder
`default_nettype none
package sbsd_pkg;
    typedef enum logic [2:0] {
        SBSD_DESEL = 3'b000,
        SBSD_READ = 3'b001,
        SBSD_WRITE = 3'b010
    } sbsd_cyc_e;
endpackage
`default_nettype wire

// ==== hw/sbsd_lane_decode.sv ====
// Lane-wise and global write qualification
`include "sbsd_consts.svh"
`default_nettype none
module sbsd_lane_decode (
    input wire logic global_write_n,
    input wire logic lane_write_gate_n,
    input wire logic [3:0] lane_write_n,
    output logic [3:0] lane_we,
    output logic write_q
);
    always_comb begin
        if (!global_write_n) begin
            lane_we = 4'hf;
        end else if (!lane_write_gate_n) begin
            lane_we = ~lane_write_n;
        end else begin
            lane_we = 4'h0;
        end
        write_q = |lane_we;
    end
endmodule
`default_nettype wire

// ==== hw/sbsd_burst_ctr.sv ====
// Two-bit burst address counter
`include "sbsd_consts.svh"
`default_nettype none
module sbsd_burst_ctr (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic advance,
    input wire logic [1:0] load_val,
    input wire logic linear_order_sel_n,
    output logic [1:0] addr
);
    logic [1:0] start_r, start_nxt, step_r, step_nxt;

    always_comb begin
        start_nxt = start_r;
        step_nxt = step_r;
        if (load) begin
            start_nxt = load_val;
            step_nxt = `SBSD_CNT_RST;
        end else if (advance) begin
            step_nxt = step_r + `SBSD_CNT_STEP;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            start_r <= `SBSD_CNT_RST;
            step_r <= `SBSD_CNT_RST;
        end else begin
            start_r <= start_nxt;
            step_r <= step_nxt;
        end
    end

    // Linear adds the step, interleaved xors it; an advancing cycle already uses the next step,
    // so a continue reaches the next address in the cycle that asks for it
    assign addr = linear_order_sel_n ? (start_r ^ step_nxt) : 2'(start_r + step_nxt);
endmodule
`default_nettype wire

// ==== hw/sbsd_core.sv ====
// Synchronous burst SRAM cycle decoder and array
`include "sbsd_consts.svh"
`default_nettype none
module sbsd_core (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [15:0] addr,
    input wire logic chip_sel_primary_n,
    input wire logic chip_sel_high,
    input wire logic chip_sel_low_n,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic lane_write_gate_n,
    input wire logic lane0_write_n,
    input wire logic lane1_write_n,
    input wire logic lane2_write_n,
    input wire logic lane3_write_n,
    input wire logic output_enable_n,
    input wire logic flow_through_sel_n,
    input wire logic linear_order_sel_n,
    input wire logic [31:0] dq_in,
    output logic [31:0] dq_out,
    output logic [3:0] dq_oe,
    output logic powered_down
);
    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic [3:0] lane_we;
    logic write_q;
    logic chip_en;
    logic [1:0] burst_addr;
    logic ctr_load, ctr_adv;
    sbsd_pkg::sbsd_cyc_e cyc;
    logic use_ext;

    sbsd_lane_decode u_lanes (
        .global_write_n(global_write_n),
        .lane_write_gate_n(lane_write_gate_n),
        .lane_write_n({lane3_write_n, lane2_write_n, lane1_write_n, lane0_write_n}),
        .lane_we(lane_we),
        .write_q(write_q)
    );

    assign chip_en = chip_sel_high & ~chip_sel_low_n;

    always_comb begin
        cyc = sbsd_pkg::SBSD_DESEL;
        use_ext = 1'b0;
        ctr_load = 1'b0;
        ctr_adv = 1'b0;
        if (!chip_sel_primary_n && (!processor_addr_strobe_n || !controller_addr_strobe_n)) begin
            if (!chip_en) begin
                cyc = sbsd_pkg::SBSD_DESEL;
            end else begin
                use_ext = 1'b1;
                ctr_load = 1'b1;
                // Processor strobe start is always a read
                if (!processor_addr_strobe_n || !write_q) begin
                    cyc = sbsd_pkg::SBSD_READ;
                end else begin
                    cyc = sbsd_pkg::SBSD_WRITE;
                end
            end
        end else if (chip_sel_primary_n && !controller_addr_strobe_n) begin
            cyc = sbsd_pkg::SBSD_DESEL;
        end else begin
            // Both strobes high or primary high with controller high
            ctr_adv = !burst_advance_n;
            cyc = write_q ? sbsd_pkg::SBSD_WRITE : sbsd_pkg::SBSD_READ;
        end
    end

    sbsd_burst_ctr u_ctr (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .load(ctr_load),
        .advance(ctr_adv),
        .load_val(addr[1:0]),
        .linear_order_sel_n(linear_order_sel_n),
        .addr(burst_addr)
    );

    // ------------------------------------------------------------
    // Array and data path
    // ------------------------------------------------------------
    // Continue and suspend use the counter output in the same cycle
    logic [15:0] eff_addr;
    logic [15:0] base_r, base_nxt;
    logic [31:0] mem [0:65535];
    logic [31:0] rd_word;

    assign eff_addr = use_ext ? addr : {base_r[15:2], burst_addr};

    always_comb begin
        base_nxt = use_ext ? addr : base_r;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            base_r <= 16'h0000;
        end else begin
            base_r <= base_nxt;
        end
    end

    // Array holds no reset; data and lanes sampled with the command
    always_ff @(posedge core_clk) begin
        if (cyc == sbsd_pkg::SBSD_WRITE) begin
            for (int i = 0; i < `SBSD_LANES; i++) begin
                if (lane_we[i]) begin
                    mem[eff_addr][i*`SBSD_LANE_W +: `SBSD_LANE_W] <= dq_in[i*`SBSD_LANE_W +: `SBSD_LANE_W];
                end
            end
        end
    end

    assign rd_word = mem[eff_addr];

    // ------------------------------------------------------------
    // Output stages
    // ------------------------------------------------------------
    // Stage 1 holds the captured cycle; stage 2 the pipelined copy
    logic s1_rd_r, s1_rd_nxt, s2_rd_r, s2_rd_nxt;
    logic [31:0] s1_dat_r, s1_dat_nxt, s2_dat_r, s2_dat_nxt;
    logic pd_r, pd_nxt;
    logic [31:0] out_nxt;
    logic [3:0] oe_nxt;
    logic [31:0] dq_out_r;
    logic [3:0] dq_oe_r;

    always_comb begin
        s1_rd_nxt = (cyc == sbsd_pkg::SBSD_READ);
        s1_dat_nxt = rd_word;
        s2_rd_nxt = s1_rd_nxt ? 1'b1 : 1'b0;
        // Deselect clears the pipelined stage at once
        if (cyc != sbsd_pkg::SBSD_READ) begin
            s2_rd_nxt = 1'b0;
        end else begin
            s2_rd_nxt = s1_rd_r;
        end
        s2_dat_nxt = s1_dat_r;
        pd_nxt = (cyc == sbsd_pkg::SBSD_DESEL);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_rd_r <= 1'b0;
            s2_rd_r <= 1'b0;
            s1_dat_r <= 32'h0000_0000;
            s2_dat_r <= 32'h0000_0000;
            pd_r <= 1'b1;
        end else begin
            s1_rd_r <= s1_rd_nxt;
            s2_rd_r <= s2_rd_nxt;
            s1_dat_r <= s1_dat_nxt;
            s2_dat_r <= s2_dat_nxt;
            pd_r <= pd_nxt;
        end
    end

    // Output enable is sampled each clock; a real pad would gate it without a clock
    always_comb begin
        if (flow_through_sel_n) begin
            out_nxt = s2_dat_r;
            oe_nxt = {4{s2_rd_r & s1_rd_r & ~output_enable_n}};
        end else begin
            out_nxt = s1_dat_r;
            oe_nxt = {4{s1_rd_r & ~output_enable_n}};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            dq_out_r <= 32'h0000_0000;
            dq_oe_r <= 4'h0;
        end else begin
            dq_out_r <= out_nxt;
            dq_oe_r <= oe_nxt;
        end
    end

    assign dq_out = dq_out_r;
    assign dq_oe = dq_oe_r;
    assign powered_down = pd_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence seq_read_cmd;
        cyc == sbsd_pkg::SBSD_READ;
    endsequence

    a_write_floats: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cyc == sbsd_pkg::SBSD_WRITE) |=> ##1 (dq_oe == 4'h0)) else $error("lanes driven after write");
    a_oe_gates: assert property (@(posedge core_clk) disable iff (!reset_n)
        output_enable_n |=> (dq_oe == 4'h0)) else $error("drivers on with oe high");
    a_desel_pd: assert property (@(posedge core_clk) disable iff (!reset_n)
        (chip_sel_primary_n && !controller_addr_strobe_n) |=> powered_down) else $error("no power down");
    a_gw_all: assert property (@(posedge core_clk) disable iff (!reset_n)
        !global_write_n |-> (lane_we == 4'hf && write_q)) else $error("global write lanes");
    a_gate_high_read: assert property (@(posedge core_clk) disable iff (!reset_n)
        (global_write_n && lane_write_gate_n) |-> !write_q) else $error("write with gate high");
    a_lane_sel: assert property (@(posedge core_clk) disable iff (!reset_n)
        (global_write_n && !lane_write_gate_n) |-> (lane_we[0] == !lane0_write_n)) else $error("lane 0");
    a_ctr_load: assert property (@(posedge core_clk) disable iff (!reset_n)
        ctr_load ##1 (!ctr_load && !ctr_adv) |-> (burst_addr == $past(addr[1:0]))) else $error("start not loaded");
    a_ctr_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!ctr_load && !ctr_adv) ##1 (!ctr_load && !ctr_adv) |-> $stable(burst_addr)) else $error("counter moved");
    a_flow_read: assert property (@(posedge core_clk) disable iff (!reset_n)
        (seq_read_cmd ##1 (!flow_through_sel_n && !output_enable_n)) |=> (dq_oe == 4'hf)) else $error("flow read");
    a_ext_start: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!chip_sel_primary_n && chip_en && !processor_addr_strobe_n) |-> seq_read_cmd) else $error("start");
endmodule
`default_nettype wire

// ==== verif/sbsd_host_model.sv ====
// Far-side bus model that resolves the shared data lanes
`default_nettype none
module sbsd_host_model (
    input wire logic core_clk,
    input wire logic [31:0] dq_out,
    input wire logic [3:0] dq_oe,
    input wire logic [31:0] wr_data,
    input wire logic wr_drive,
    output logic [31:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] last = 32'h0;
    // Undriven lanes show the inverse of the last value, so a stale read cannot pass
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (wr_drive)
                dq_in[8*i+:8] = wr_data[8*i+:8];
            else
                dq_in[8*i+:8] = dq_oe[i] ? dq_out[8*i+:8] : ~last[8*i+:8];
        end
    end
    always @(posedge core_clk) last <= dq_in;
endmodule
`default_nettype wire

// ==== verif/sbsd_core_tb_top.sv ====
// Self-checking bench for the burst SRAM command decoder
`default_nettype none
module sbsd_core_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // Commands pack {sel_n, sel_ok, p_n, c_n, step_n}
    // ----
    localparam logic [4:0] ST_C = 5'h0d, ST_P = 5'h0b, CONT = 5'h1e, SUSP = 5'h0f, DES = 5'h15;
    logic core_clk = 1'b0, reset_n = 1'b0, sel_n = 1'b1, sel_ok = 1'b0, p_n = 1'b1, c_n = 1'b1;
    logic step_n = 1'b1, glob_n = 1'b1, gate_n = 1'b1, oe_n = 1'b0, flow_n = 1'b0, ord_n = 1'b0;
    logic drv = 1'b0, powered_down;
    logic [3:0] lane_n = 4'hf, dq_oe;
    logic [15:0] addr = 16'h0;
    logic [31:0] wd = 32'h0, dq_in, dq_out;
    logic [31:0] mem [int];
    logic [3:0] lanes [5] = '{4'he, 4'hd, 4'hb, 4'h7, 4'h5};
    logic [4:0] desel [3] = '{5'h15, 5'h03, 5'h05};
    logic [3:0] q_oe [$];
    logic [31:0] q_d [$];
    bit q_c [$];
    int err_total = 0, n_checks = 0, lat = 2, st = 0, n = 0, ba = 0;
    always #50 core_clk = ~core_clk;
    sbsd_core sbsd_core_i (.core_clk(core_clk), .reset_n(reset_n), .addr(addr), .chip_sel_primary_n(sel_n),
        .chip_sel_high(sel_ok), .chip_sel_low_n(~sel_ok), .processor_addr_strobe_n(p_n),
        .controller_addr_strobe_n(c_n), .burst_advance_n(step_n), .global_write_n(glob_n),
        .lane_write_gate_n(gate_n), .lane0_write_n(lane_n[0]), .lane1_write_n(lane_n[1]),
        .lane2_write_n(lane_n[2]), .lane3_write_n(lane_n[3]), .output_enable_n(oe_n),
        .flow_through_sel_n(flow_n), .linear_order_sel_n(ord_n), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .powered_down(powered_down));
    sbsd_host_model sbsd_host_model_i (.core_clk(core_clk), .dq_out(dq_out), .dq_oe(dq_oe),
        .wr_data(wd), .wr_drive(drv), .dq_in(dq_in));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Issue one command at a falling edge and check the data phase now due
    task automatic go(input logic [4:0] cmd, input logic [15:0] a, input bit c = 1'b1);
        logic [3:0] m;
        logic des, wq;
        int k;
        {sel_n, sel_ok, p_n, c_n, step_n} = cmd;
        addr = a;
        m = !glob_n ? 4'hf : !gate_n ? ~lane_n : 4'h0;
        wq = m != 4'h0;
        des = (sel_n && !c_n) || (!sel_n && !sel_ok && !(p_n && c_n));
        if (!des && !sel_n && !(p_n && c_n)) begin
            ba = a[15:2];
            st = a[1:0];
            n = 0;
            wq = wq && p_n;
        end else if (!des && !step_n) begin
            n++;
        end
        k = ba * 4 + ((ord_n ? st ^ n : st + n) & 3);
        drv = wq && !des;
        for (int i = 0; i < 4; i++)
            if (drv && m[i])
                mem[k][8*i+:8] = wd[8*i+:8];
        // Deselect timing of reads still in flight is left open, so those are not judged
        foreach (q_c[i])
            if (des && i + lat > q_c.size())
                q_c[i] = 1'b0;
        if (q_c.size() > 0 && oe_n)
            q_oe[q_oe.size() - 1] = 4'h0;
        q_oe.push_back(!des && !wq ? 4'hf : 4'h0);
        q_d.push_back(mem.exists(k) ? mem[k] : 32'h0);
        q_c.push_back(c);
        @(negedge core_clk);
        if (q_c.size() >= lat) begin
            if (q_c[0])
                chk("dq_oe", {28'h0, dq_oe}, {28'h0, q_oe[0]});
            if (q_c[0] && q_oe[0] != 4'h0)
                chk("dq_out", dq_out, q_d[0]);
            void'(q_c.pop_front());
            void'(q_oe.pop_front());
            void'(q_d.pop_front());
        end
    endtask
    initial begin
        repeat (16) @(negedge core_clk);
        chk("dq_oe", {28'h0, dq_oe}, 32'h0);
        chk("powered_down", {31'h0, powered_down}, 32'h1);
        reset_n = 1'b1;
        glob_n = 1'b0;
        for (int i = 0; i < 8; i++) begin
            wd = 32'h01030507 * 32'(i + 1);
            go(ST_C, 16'h0100 + 16'(i));
        end
        glob_n = 1'b1;
        for (int i = 0; i < 8; i++)
            go(ST_C, 16'h0100 + 16'(i));
        gate_n = 1'b0;
        foreach (lanes[j]) begin
            lane_n = lanes[j];
            wd = 32'hc3c3c3c3 ^ 32'(j);
            go(ST_C, 16'h0100 + 16'(j));
        end
        lane_n = 4'hf;
        for (int i = 0; i < 5; i++)
            go(ST_C, 16'h0100 + 16'(i));
        gate_n = 1'b1;
        for (int o = 0; o < 2; o++) begin
            ord_n = o[0];
            go(o == 0 ? ST_P : ST_C, 16'h0101);
            repeat (2) go(CONT, 16'h0);
            repeat (2) go(5'h06, 16'h0);
            go(SUSP, 16'h0);
        end
        glob_n = 1'b0;
        wd = 32'h5a5a0001;
        go(ST_C, 16'h0104);
        wd = 32'h5a5a0002;
        go(CONT, 16'h0);
        wd = 32'h5a5a0003;
        go(SUSP, 16'h0);
        glob_n = 1'b1;
        go(ST_C, 16'h0104);
        go(ST_C, 16'h0105);
        oe_n = 1'b1;
        go(ST_C, 16'h0100);
        go(CONT, 16'h0);
        glob_n = 1'b0;
        wd = 32'h0f0f0f0f;
        go(CONT, 16'h0);
        oe_n = 1'b0;
        glob_n = 1'b1;
        go(ST_C, 16'h0102);
        chk("powered_down", {31'h0, powered_down}, 32'h0);
        foreach (desel[j]) begin
            go(desel[j], 16'h0);
            chk("powered_down", {31'h0, powered_down}, 32'h1);
        end
        lat = 3;
        flow_n = 1'b1;
        go(DES, 16'h0);
        go(ST_C, 16'h0100, 1'b0);
        repeat (4) go(CONT, 16'h0);
        repeat (2) go(DES, 16'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
